//--- shared/mifeb_pkg.sv
package mifeb_pkg;
  localparam int NREG = 9;
  localparam logic [3:0] IDX_EDGE = 4'h0;
  localparam logic [3:0] IDX_CTRL_A = 4'h1;
  localparam logic [3:0] IDX_CTRL_B = 4'h2;
  localparam logic [3:0] IDX_CTRL_C = 4'h3;
  localparam logic [3:0] IDX_CTRL_D = 4'h4;
  localparam logic [3:0] IDX_SEC_TA = 4'h5;
  localparam logic [3:0] IDX_SEC_TB = 4'h6;
  localparam logic [3:0] IDX_SEC_PA = 4'h7;
  localparam logic [3:0] IDX_SEC_PB = 4'h8;
  localparam int IDX_SEC0 = 5;
  // Implemented-bit masks; unimplemented bits store and read as zero
  localparam logic [7:0] MASK_EDGE_FULL = 8'hff;
  localparam logic [7:0] MASK_EDGE_TWO = 8'h0f;
  localparam logic [7:0] MASK_CTRL_A = 8'h7f;
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] MASK_CTRL_D = 8'h33;
  localparam logic [7:0] MASK_SEC_GAP = 8'h77;
  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Bit positions
  localparam int B_GIE = 0;
  localparam int B_A_CMP0 = 6;
  localparam int B_A_EXT1 = 5;
  localparam int B_A_EXT0 = 4;
  localparam int B_B_ADC = 7;
  localparam int B_B_MF1 = 6;
  localparam int B_B_MF0 = 5;
  localparam int B_B_CMP1 = 4;
  localparam int B_C_MF3 = 7;
  localparam int B_C_TB1 = 6;
  localparam int B_C_TB0 = 5;
  localparam int B_C_MF2 = 4;
  localparam int B_D_EXT3 = 5;
  localparam int B_D_EXT2 = 4;
  localparam int B_PA_XP = 5;
  localparam int NPIN = 4;
  localparam int FLD_W = 2;
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } mifeb_req_t;

  typedef struct packed {
    logic cmp0;
    logic cmp1;
    logic adc;
    logic tb0;
    logic tb1;
    logic [15:0] sec;
  } mifeb_evt_t;
endpackage : mifeb_pkg

//--- core/mifeb_bank.sv
// Notes on behaviour
// - Edge field: 00 off, 01 rising, 10 falling, 11 both edges set flag.
// - Edge register bits 1~0 pin 0, bits 3~2 pin 1.
// - Largest variant: bits 5~4 pin 2, bits 7~6 pin 3.
// - Two-pin variant: edge register bits 7~4 read zero.
// - Global enable in ctrl A bit 0; 1 forwards interrupts to core.
// - Each source except evt.sec[7] and evt.sec[15] has software read/write flag and enable bit.
// - Ctrl A bits 6..1: cmp0 flag, ext1, ext0 flags, cmp0, ext1, ext0 enables.
// - Ctrl B: adc, multi1, multi0, cmp1 flags, then matching enables.
// - Ctrl C: multi3, timebase1, timebase0, multi2 flags, then enables.
// - Ctrl D holds ext pins 2 and 3, largest variant only.
// - Four secondary registers hold grouped source flag/enable pairs.
// - Edge pins and peripheral pin raise external requests.
// - One edge select register configures all edge pins.
// - Ctrl A bit 7 reads zero.
// - Flag sets even when disabled; no request then.
// - Global enable clear blocks all interrupt requests.
// - Service clears global enable; later events still set flags.
`timescale 1ns/1ps
module mifeb_bank #(
  parameter bit FOUR_PINS = 1'b1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Register access
  input mifeb_pkg::mifeb_req_t req,
  output logic [7:0] rd_data_r,
  // Event sources
  input wire logic [mifeb_pkg::NPIN-1:0] edge_irq_pins,
  input wire logic peripheral_irq_pin,
  input mifeb_pkg::mifeb_evt_t evt,
  // Core vectoring side
  input wire logic irq_ack,
  output logic irq_req_r,
  output logic [15:0] irq_pending_r
);
  import mifeb_pkg::*;

  logic [7:0] regs_r [NREG];
  logic [7:0] regs_nxt [NREG];
  logic [7:0] set_v [NREG];
  logic [7:0] mask_v [NREG];
  logic [NPIN-1:0] pins_prev_r;
  logic [NPIN-1:0] rise;
  logic [NPIN-1:0] fall;
  logic [NPIN-1:0] ext_evt;
  logic xp_prev_r;
  logic xp_evt;
  logic [3:0] multi_set;
  logic [15:0] pending;
  logic any_pend;
  logic [7:0] rd_sel;
  logic addr_ok;
  logic gie;

  // Edge detection on synchronous pins
  assign rise = edge_irq_pins & ~pins_prev_r;
  assign fall = ~edge_irq_pins & pins_prev_r;
  // Peripheral pin requests on its rising edge
  assign xp_evt = peripheral_irq_pin & ~xp_prev_r;

  genvar gp;
  generate
    for (gp = 0; gp < NPIN; gp++) begin : g_pin
      logic [1:0] fld;
      // One edge select register serves every pin
      assign fld = regs_r[IDX_EDGE][gp*FLD_W +: FLD_W];
      assign ext_evt[gp] = (fld[0] & rise[gp]) | (fld[1] & fall[gp]);
    end
  endgenerate

  // Multi-function group n follows secondary register n
  genvar gm;
  generate
    for (gm = 0; gm < 4; gm++) begin : g_multi
      assign multi_set[gm] = |(regs_r[IDX_SEC0+gm][7:4]
                               & regs_r[IDX_SEC0+gm][3:0]);
    end
  endgenerate

  assign mask_v[IDX_EDGE] = FOUR_PINS ? MASK_EDGE_FULL : MASK_EDGE_TWO;
  assign mask_v[IDX_CTRL_A] = MASK_CTRL_A;
  assign mask_v[IDX_CTRL_B] = MASK_FULL;
  assign mask_v[IDX_CTRL_C] = MASK_FULL;
  assign mask_v[IDX_CTRL_D] = FOUR_PINS ? MASK_CTRL_D : MASK_NONE;
  assign mask_v[IDX_SEC_TA] = MASK_FULL;
  assign mask_v[IDX_SEC_TB] = MASK_SEC_GAP;
  assign mask_v[IDX_SEC_PA] = MASK_FULL;
  assign mask_v[IDX_SEC_PB] = MASK_SEC_GAP;

  // Hardware set vectors; flags set regardless of their enables
  assign set_v[IDX_EDGE] = 8'h00;
  assign set_v[IDX_CTRL_A] = {1'b0, evt.cmp0, ext_evt[1], ext_evt[0],
                              4'h0};
  assign set_v[IDX_CTRL_B] = {evt.adc, multi_set[1], multi_set[0],
                              evt.cmp1, 4'h0};
  assign set_v[IDX_CTRL_C] = {multi_set[3], evt.tb1, evt.tb0,
                              multi_set[2], 4'h0};
  assign set_v[IDX_CTRL_D] = {2'h0, ext_evt[3], ext_evt[2], 4'h0};
  assign set_v[IDX_SEC_TA] = {evt.sec[3:0], 4'h0};
  assign set_v[IDX_SEC_TB] = {evt.sec[7:4], 4'h0};
  assign set_v[IDX_SEC_PA] = {evt.sec[11:10], evt.sec[9] | xp_evt,
                              evt.sec[8], 4'h0};
  assign set_v[IDX_SEC_PB] = {evt.sec[15:12], 4'h0};

  assign gie = regs_r[IDX_CTRL_A][B_GIE];

  genvar gr;
  generate
    for (gr = 0; gr < NREG; gr++) begin : g_reg
      logic hit;
      logic [7:0] base;
      assign hit = req.wr && (req.addr == 4'(gr));
      assign base = hit ? req.wdata : regs_r[gr];
      // Service only clears the global enable, and a write wins over it
      if (gr == IDX_CTRL_A) begin : g_gie
        logic [7:0] acked;
        assign acked = (irq_ack && !hit) ? (base & ~8'h01) : base;
        assign regs_nxt[gr] = (acked | set_v[gr]) & mask_v[gr];
      end else begin : g_plain
        // Set wins over a clearing write in the same cycle
        assign regs_nxt[gr] = (base | set_v[gr]) & mask_v[gr];
      end
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          regs_r[gr] <= REG_RESET;
        end else begin
          regs_r[gr] <= regs_nxt[gr];
        end
      end
    end
  endgenerate

  // Primary flag and enable pairs seen by the core
  assign pending = {regs_r[IDX_CTRL_D][5:4] & regs_r[IDX_CTRL_D][1:0],
                    regs_r[IDX_CTRL_C][7:4] & regs_r[IDX_CTRL_C][3:0],
                    regs_r[IDX_CTRL_B][7:4] & regs_r[IDX_CTRL_B][3:0],
                    regs_r[IDX_CTRL_A][6:4] & regs_r[IDX_CTRL_A][3:1],
                    3'h0};
  assign any_pend = |pending;

  assign addr_ok = req.addr < NREG[3:0];
  assign rd_sel = addr_ok ? regs_r[req.addr] : 8'h00;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pins_prev_r <= '0;
      xp_prev_r <= 1'b0;
      rd_data_r <= 8'h00;
      irq_req_r <= 1'b0;
      irq_pending_r <= 16'h0000;
    end else begin
      pins_prev_r <= edge_irq_pins;
      xp_prev_r <= peripheral_irq_pin;
      if (req.rd) begin
        rd_data_r <= rd_sel;
      end
      // Gated by irq_ack so the request is low from the cycle after the ack, when gie clears, and the core never sees a stale request
      irq_req_r <= gie & any_pend & ~irq_ack;
      irq_pending_r <= pending;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  AST_EDGE_RISE_SETS: assert property (
    (regs_r[IDX_EDGE][1:0] == EDGE_RISE) && rise[0] |=>
      regs_r[IDX_CTRL_A][B_A_EXT0])
    else $error("rising edge on pin 0 did not set its flag");

  AST_EDGE_OFF_QUIET: assert property (
    (regs_r[IDX_EDGE][3:2] == EDGE_OFF) && !regs_r[IDX_CTRL_A][B_A_EXT1]
      && !req.wr |=> !regs_r[IDX_CTRL_A][B_A_EXT1])
    else $error("pin 1 flag set while its edge field is off");

  AST_EDGE_FALL_ONLY: assert property (
    (regs_r[IDX_EDGE][3:2] == EDGE_FALL) && fall[1] |=>
      regs_r[IDX_CTRL_A][B_A_EXT1])
    else $error("falling edge on pin 1 did not set its flag");

  AST_CTRL_A_TOP_ZERO: assert property (
    req.rd && (req.addr == IDX_CTRL_A) |=> rd_data_r[7] == 1'b0)
    else $error("ctrl A bit 7 read as one");

  AST_EDGE_HIGH_ZERO: assert property (
    !FOUR_PINS && req.rd && (req.addr == IDX_EDGE) |=>
      rd_data_r[7:4] == 4'h0)
    else $error("edge register upper bits read nonzero");

  AST_GIE_BLOCKS: assert property (
    !gie |=> !irq_req_r)
    else $error("request raised while global enable clear");

  AST_ACK_CLEARS_GIE: assert property (
    irq_ack && !(req.wr && req.addr == IDX_CTRL_A) |=> !gie ##1 !irq_req_r)
    else $error("service did not clear global enable");

  AST_DISABLED_FLAG_SETS: assert property (
    evt.cmp0 && !regs_r[IDX_CTRL_A][3] && !(req.wr && req.addr == IDX_CTRL_A)
      |=> regs_r[IDX_CTRL_A][B_A_CMP0] && !pending[B_A_CMP0 - 1])
    else $error("disabled comparator event lost or requested");

  AST_MULTI_FROM_SEC: assert property (
    multi_set[0] |=> regs_r[IDX_CTRL_B][B_B_MF0])
    else $error("multi-function 0 flag missed secondary request");

  AST_RW_STORE: assert property (
    req.wr && (req.addr == IDX_CTRL_B) && !evt.adc && !evt.cmp1
      && multi_set[1:0] == 2'h0 |=> regs_r[IDX_CTRL_B] == $past(req.wdata))
    else $error("ctrl B write not stored");

  AST_REQ_FOLLOWS_PEND: assert property (
    gie && any_pend && !irq_ack |=> irq_req_r)
    else $error("enabled pending source gave no request");

  // Reset is checked with the default disable lifted
  AST_RESET_OUTPUTS: assert property (disable iff (1'b0)
    !arst_n ##1 !arst_n |-> rd_data_r == 8'h00 && !irq_req_r
      && irq_pending_r == 16'h0000 && regs_r[IDX_CTRL_A] == REG_RESET)
    else $error("outputs or registers not cleared in reset");

  // Service and request gating
  AST_GIE_WRITE: assert property (
    req.wr && (req.addr == IDX_CTRL_A)
      |=> gie == $past(req.wdata[B_GIE]))
    else $error("global enable did not take the written value");

  AST_NO_REQ_DISABLED: assert property (
    regs_r[IDX_CTRL_A][3:1] == 3'h0 && regs_r[IDX_CTRL_B][3:0] == 4'h0
      && regs_r[IDX_CTRL_C][3:0] == 4'h0 && regs_r[IDX_CTRL_D][1:0] == 2'h0
      |=> !irq_req_r)
    else $error("request raised with every source disabled");

  AST_ACK_KEEPS_FLAGS: assert property (
    irq_ack && regs_r[IDX_CTRL_A][B_A_EXT0]
      && !(req.wr && req.addr == IDX_CTRL_A)
      |=> regs_r[IDX_CTRL_A][B_A_EXT0])
    else $error("service cleared a pending flag");

  // Edge decode on pins 0, 2 and 3
  AST_EDGE_BOTH_FALL: assert property (
    (regs_r[IDX_EDGE][1:0] == EDGE_BOTH) && fall[0]
      |=> regs_r[IDX_CTRL_A][B_A_EXT0])
    else $error("falling edge on pin 0 missed in both-edge mode");

  AST_RISE_IGNORES_FALL: assert property (
    (regs_r[IDX_EDGE][1:0] == EDGE_RISE) && fall[0] && !req.wr
      && !regs_r[IDX_CTRL_A][B_A_EXT0] |=> !regs_r[IDX_CTRL_A][B_A_EXT0])
    else $error("falling edge on pin 0 set flag in rising mode");

  AST_PIN2_RISE_SETS: assert property (
    (regs_r[IDX_EDGE][5:4] == EDGE_RISE) && rise[2]
      |=> regs_r[IDX_CTRL_D][B_D_EXT2])
    else $error("rising edge on pin 2 did not set its flag");

  AST_PIN3_FALL_SETS: assert property (
    (regs_r[IDX_EDGE][7:6] == EDGE_FALL) && fall[3]
      |=> regs_r[IDX_CTRL_D][B_D_EXT3])
    else $error("falling edge on pin 3 did not set its flag");

  // Unimplemented bits never read back as one
  AST_CTRL_D_GAPS: assert property (
    req.rd && (req.addr == IDX_CTRL_D) |=> rd_data_r[7:6] == 2'h0
      && rd_data_r[3:2] == 2'h0 && (FOUR_PINS || rd_data_r == 8'h00))
    else $error("ctrl D read outside its implemented bits");

  AST_SEC_GAP_ZERO: assert property (
    req.rd && (req.addr == IDX_SEC_TB)
      |=> rd_data_r[7] == 1'b0 && rd_data_r[3] == 1'b0)
    else $error("timer B secondary gap bits read nonzero");

  // Each source event except evt.sec[7] and evt.sec[15] sets its flag one cycle later
  AST_SEC_TA_SETS: assert property (
    evt.sec[3:0] != 4'h0
      |=> regs_r[IDX_SEC_TA][7:4] != 4'h0)
    else $error("timer A secondary event lost");

  AST_PERIPH_PIN_SETS: assert property (
    xp_evt
      |=> regs_r[IDX_SEC_PA][B_PA_XP])
    else $error("peripheral pin edge did not set its flag");

  AST_ADC_SETS: assert property (
    evt.adc
      |=> regs_r[IDX_CTRL_B][B_B_ADC])
    else $error("converter done event did not set its flag");

  AST_TB1_SETS: assert property (
    evt.tb1
      |=> regs_r[IDX_CTRL_C][B_C_TB1])
    else $error("time base 1 event did not set its flag");

  AST_MULTI3_FROM_SEC: assert property (
    |(regs_r[IDX_SEC_PB][6:4] & regs_r[IDX_SEC_PB][2:0])
      |=> regs_r[IDX_CTRL_C][B_C_MF3])
    else $error("multi-function 3 flag missed secondary request");

  COV_EDGE_BOTH: cover property (
    (regs_r[IDX_EDGE][1:0] == EDGE_BOTH) && fall[0]);
  COV_SERVICE: cover property (irq_req_r ##1 irq_ack);
  COV_PERIPH_PIN: cover property (xp_evt ##1 regs_r[IDX_SEC_PA][B_PA_XP]);
  COV_MULTI3: cover property (multi_set[3]);
  COV_ACK_WITH_FLAG: cover property (irq_ack && regs_r[IDX_CTRL_A][4]);
endmodule : mifeb_bank

//--- bench/mifeb_core_model.sv
`timescale 1ns/1ps
module mifeb_core_model (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Vectoring handshake
  input wire logic irq_req_r,
  input wire logic [3:0] lag,
  output logic irq_ack
);
  logic [3:0] wait_r;
  logic take;
  // Core only vectors once its current instruction has run for lag cycles
  assign take = irq_req_r && !irq_ack;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wait_r <= 4'h0;
      irq_ack <= 1'b0;
    end else begin
      irq_ack <= take && wait_r == lag;
      wait_r <= (take && wait_r != lag) ? wait_r + 4'h1 : 4'h0;
    end
  end
endmodule : mifeb_core_model

//--- bench/mcu_interrupt_flag_enable_bank_bench.sv
`timescale 1ns/1ps
module mcu_interrupt_flag_enable_bank_bench;
  import mifeb_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  mifeb_req_t req = '0;
  logic [7:0] rd_data_r;
  logic [7:0] rd_two;
  logic [NPIN-1:0] edge_irq_pins = '0;
  logic peripheral_irq_pin = 1'b0;
  mifeb_evt_t evt = '0;
  logic irq_ack;
  logic irq_req_r;
  logic [15:0] irq_pending_r;
  logic [3:0] lag = 4'h3;
  logic [7:0] v;
  logic [7:0] masks [10] = '{8'hff, 8'h7f, 8'hff, 8'hff, 8'h33,
    8'hff, 8'h77, 8'hff, 8'h77, 8'h00};
  int errors = 0;
  int n_compared = 0;

  always #2 clock = ~clock;

  mifeb_bank #(.FOUR_PINS(1'b1)) mifeb_bank_inst (.clock(clock),
    .arst_n(arst_n), .req(req), .rd_data_r(rd_data_r),
    .edge_irq_pins(edge_irq_pins), .peripheral_irq_pin(peripheral_irq_pin),
    .evt(evt), .irq_ack(irq_ack), .irq_req_r(irq_req_r),
    .irq_pending_r(irq_pending_r));
  mifeb_core_model mifeb_core_model_inst (.clock(clock), .arst_n(arst_n),
    .irq_req_r(irq_req_r), .lag(lag), .irq_ack(irq_ack));
  // Two-pin variant runs beside the full one on the same stimulus
  mifeb_bank #(.FOUR_PINS(1'b0)) mifeb_bank_two_inst (.clock(clock),
    .arst_n(arst_n), .req(req), .rd_data_r(rd_two),
    .edge_irq_pins(edge_irq_pins), .peripheral_irq_pin(peripheral_irq_pin),
    .evt(evt), .irq_ack(irq_ack), .irq_req_r(), .irq_pending_r());

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clock) req = '{1'b1, 1'b0, a, d};
    @(negedge clock) req = '0;
  endtask : wr

  task rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clock) req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clock) req = '0;
    d = rd_data_r;
  endtask : rd

  task chk(input string nm, input logic [15:0] seen, input logic [15:0] ex);
    n_compared++;
    if (seen !== ex) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk

  task results;
    if (errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  initial begin
    int k;
    repeat (2) @(negedge clock);
    arst_n = 1'b1;
    for (int i = 0; i < 10; i++) begin
      rd(4'(i), v);
      chk("reset value", v, 16'h0);
      chk("two-pin reset", rd_two, 16'h0);
    end
    // Index 9 is unmapped and must swallow the write
    for (int i = 0; i < 10; i++) begin
      wr(4'(i), 8'hff);
      rd(4'(i), v);
      chk("writable bits", v, masks[i]);
      chk("two-pin bits", rd_two,
        i == 0 ? 16'h000f : i == 4 ? 16'h0000 : 16'(masks[i]));
      wr(4'(i), 8'h00);
    end
    for (int p = 0; p < 4; p++)
      for (int m = 0; m < 4; m++) begin
        wr(IDX_EDGE, 8'(m << (2 * p)));
        for (int e = 0; e < 2; e++) begin
          wr(IDX_CTRL_A, 8'h00);
          wr(IDX_CTRL_D, 8'h00);
          @(negedge clock) edge_irq_pins[p] = (e == 0);
          repeat (2) @(negedge clock);
          rd(p < 2 ? IDX_CTRL_A : IDX_CTRL_D, v);
          chk("edge flag", v[4 + p % 2], 16'((m >> e) & 1));
          chk("two-pin edge", rd_two[4 + p % 2],
            p < 2 ? 16'((m >> e) & 1) : 16'h0000);
        end
      end
    wr(IDX_CTRL_B, 8'h00);
    wr(IDX_CTRL_C, 8'h00);
    wr(IDX_CTRL_D, 8'h00);
    @(negedge clock) evt = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 16'h0};
    @(negedge clock) evt = '0;
    repeat (2) @(negedge clock);
    rd(IDX_CTRL_A, v);
    chk("ctrl a flags", v, 16'h40);
    rd(IDX_CTRL_C, v);
    chk("ctrl c flags", v, 16'h60);
    wr(IDX_SEC_TA, 8'h01);
    wr(IDX_SEC_PA, 8'h02);
    @(negedge clock) evt.sec = 16'h0001;
    peripheral_irq_pin = 1'b1;
    @(negedge clock) evt = '0;
    repeat (4) @(negedge clock);
    rd(IDX_CTRL_B, v);
    chk("ctrl b flags", v, 16'hb0);
    rd(IDX_SEC_TA, v);
    chk("timer a pair", v, 16'h11);
    rd(IDX_SEC_PA, v);
    chk("periph pin flag", v, 16'h22);
    rd(IDX_CTRL_C, v);
    chk("multi2 flag", v, 16'h70);
    wr(IDX_CTRL_B, 8'h00);
    wr(IDX_CTRL_C, 8'h00);
    wr(IDX_CTRL_A, 8'h00);
    wr(IDX_EDGE, 8'h01);
    wr(IDX_CTRL_A, 8'h01);
    @(negedge clock) edge_irq_pins[0] = 1'b1;
    repeat (3) @(negedge clock);
    chk("disabled request", {irq_pending_r[3], irq_req_r}, 16'h0);
    rd(IDX_CTRL_A, v);
    chk("disabled flag", v, 16'h11);
    wr(IDX_CTRL_A, 8'h13);
    for (k = 0; k < 20 && irq_ack !== 1'b1; k++) @(negedge clock);
    if (k == 20) begin
      errors++;
      results;
    end
    chk("pending at service", irq_pending_r[3], 16'h1);
    repeat (2) @(negedge clock);
    chk("blocked request", irq_req_r, 16'h0);
    rd(IDX_CTRL_A, v);
    chk("service clears gie", v, 16'h12);
    results;
  end
endmodule : mcu_interrupt_flag_enable_bank_bench
